// [core/adr_pkg.sv]
// Shared constants, field layout and helper functions of the sample readout port.
package adr_pkg;

  // ----------------------------------------------------------------
  // Host I/O map
  // ----------------------------------------------------------------
  localparam int             ADR_ADDR_W      = 4;
  localparam logic [3:0]     ADR_OFFS_LOW    = 4'h0;
  localparam logic [3:0]     ADR_OFFS_HIGH   = 4'h1;

  // ----------------------------------------------------------------
  // Sample layout and reset values
  // ----------------------------------------------------------------
  localparam int             ADR_SAMPLE_W    = 16;
  localparam int             ADR_BYTE_W      = 8;
  localparam int             ADR_LOW_LSB     = 0;
  localparam int             ADR_HIGH_LSB    = 8;
  localparam int             ADR_FIFO_DEPTH  = 16;
  localparam logic [15:0]    ADR_SAMPLE_RST  = 16'h0000;
  localparam logic [7:0]     ADR_BYTE_RST    = 8'h00;
  localparam logic [7:0]     ADR_BYTE_PAD    = 8'h00;

  // ----------------------------------------------------------------
  // Range code field: {unipolar, gain high, gain low}
  // ----------------------------------------------------------------
  localparam int             ADR_RANGE_W     = 3;
  localparam int             ADR_RANGE_UNI   = 2;
  localparam int             ADR_RANGE_G1    = 1;
  localparam int             ADR_RANGE_G0    = 0;
  localparam logic [2:0]     ADR_RANGE_RST   = 3'h0;

  // ----------------------------------------------------------------
  // Output coding
  // ----------------------------------------------------------------
  function automatic logic [15:0] adr_encode(input logic [15:0] raw, input logic invert);
    adr_encode = invert ? ~raw : raw;
  endfunction

  function automatic logic [7:0] adr_byte(input logic [15:0] word, input logic high);
    adr_byte = high ? word[ADR_HIGH_LSB +: ADR_BYTE_W] : word[ADR_LOW_LSB +: ADR_BYTE_W];
  endfunction

endpackage

// [core/adr_stream_if.sv]
// Valid/ready stream carrier between the readout port and its sample FIFO.
`timescale 1ns/1ps
interface adr_stream_if #(
  parameter int WIDTH = 16
);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;

  modport producer (output valid, output data, input ready);
  modport consumer (input valid, input data, output ready);
endinterface

// [core/adr_sync.sv]
// Two-stage synchroniser for strap and pin levels.
`timescale 1ns/1ps
module adr_sync import adr_pkg::*; #(
  parameter int WIDTH = 1
) (
  input  wire logic             clock_in,
  input  wire logic             reset_n_in,
  input  wire logic [WIDTH-1:0] level_in,
  output logic      [WIDTH-1:0] level_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } adr_sync_s;

  adr_sync_s st;
  adr_sync_s next_st;

  always_comb begin
    next_st        = st;
    next_st.stage1 = level_in;
    next_st.stage2 = st.stage1;
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level_out = st.stage2;

endmodule

// [core/adr_fifo.sv]
// Sample FIFO with parameterised width and depth and valid/ready on both sides.
`timescale 1ns/1ps
module adr_fifo import adr_pkg::*; #(
  parameter int WIDTH = ADR_SAMPLE_W,
  parameter int DEPTH = ADR_FIFO_DEPTH
) (
  input  wire logic   clock_in,
  input  wire logic   reset_n_in,
  input  wire logic   flush_in,
  adr_stream_if.consumer wr_port,
  adr_stream_if.producer rd_port
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0]   count;
  } adr_fifo_s;

  adr_fifo_s        st;
  adr_fifo_s        next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign wr_port.ready = (st.count != DEPTH[AW:0]) && !flush_in;
  assign rd_port.valid = (st.count != '0) && !flush_in;
  assign rd_port.data  = mem[st.rd_ptr];
  assign push          = wr_port.valid && wr_port.ready;
  assign pop           = rd_port.valid && rd_port.ready;

  // ----------------------------------------------------------------
  // Pointer and occupancy update
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    if (flush_in) begin
      next_st = '0;
    end else begin
      if (push) begin
        next_st.wr_ptr = (st.wr_ptr == AW'(DEPTH - 1)) ? '0 : st.wr_ptr + 1'b1;
      end
      if (pop) begin
        next_st.rd_ptr = (st.rd_ptr == AW'(DEPTH - 1)) ? '0 : st.rd_ptr + 1'b1;
      end
      next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Storage carries no reset; occupancy alone decides what is valid.
  always_ff @(posedge clock_in) begin
    if (push) begin
      mem[st.wr_ptr] <= wr_port.data;
    end
  end

endmodule

// [core/adr_readout_port.sv]
// Host-side readout port for converter samples: byte, word and FIFO readout plus software trigger.
//
// Functional notes
// - Sample low byte offset 0, high byte offset 1.
// - Word read at offset 0 returns both bytes.
// - Direct mode: bytes readable in any order.
// - Write to low offset issues software trigger.
// - FIFO strap: reads come from sample FIFO.
// - High byte read pops FIFO when not empty.
// - Acquisition never pauses because of readout.
// - Straight binary: zero negative, all-ones positive.
// - Inverted coding complements every straight code.
// - Gain bits and unipolar strap pick range.
`timescale 1ns/1ps
module adr_readout_port import adr_pkg::*; #(
  parameter int FIFO_DEPTH = ADR_FIFO_DEPTH
) (
  input  wire logic                    clock_in,
  input  wire logic                    reset_n_in,
  input  wire logic [ADR_ADDR_W-1:0]   io_address_in,
  input  wire logic                    io_read_in,
  input  wire logic                    io_write_in,
  input  wire logic                    io_word_in,
  input  wire logic [ADR_BYTE_W-1:0]   io_write_data_in,
  output logic      [ADR_SAMPLE_W-1:0] io_read_data_out,
  output logic                         io_read_valid_out,
  input  wire logic                    sample_valid_in,
  input  wire logic [ADR_SAMPLE_W-1:0] sample_data_in,
  output logic                         sample_ready_out,
  output logic                         sw_trigger_out,
  output logic      [ADR_BYTE_W-1:0]   sw_trigger_data_out,
  input  wire logic                    fifo_mode_strap_in,
  input  wire logic                    unipolar_strap_in,
  input  wire logic                    gain_select_high_in,
  input  wire logic                    gain_select_low_in,
  input  wire logic                    invert_encoding_in,
  output logic      [ADR_RANGE_W-1:0]  range_code_out,
  output logic                         range_bipolar_out,
  output logic                         fifo_mode_out,
  output logic                         fifo_empty_out,
  output logic                         fifo_full_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                    fifo_mode;
    logic [ADR_SAMPLE_W-1:0] latest;
    logic [ADR_SAMPLE_W-1:0] read_data;
    logic                    read_valid;
    logic                    trigger;
    logic [ADR_BYTE_W-1:0]   trigger_data;
    logic [ADR_RANGE_W-1:0]  range_code;
  } adr_port_s;

  adr_port_s               st;
  adr_port_s               next_st;
  logic [1:0]              strap_sync;
  logic                    fifo_strap;
  logic                    unipolar;
  logic                    mode_change;
  logic                    read_low;
  logic                    read_high;
  logic                    write_low;
  logic                    consume;
  logic [ADR_SAMPLE_W-1:0] head;
  logic [ADR_SAMPLE_W-1:0] coded;

  adr_stream_if #(.WIDTH(ADR_SAMPLE_W)) push_if ();
  adr_stream_if #(.WIDTH(ADR_SAMPLE_W)) pop_if ();

  // ----------------------------------------------------------------
  // Strap synchronisation
  // ----------------------------------------------------------------
  // Jumpers are board pins, so both pass two flops before any logic sees them.
  adr_sync #(
    .WIDTH (2)
  ) u_strap_sync (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .level_in   ({fifo_mode_strap_in, unipolar_strap_in}),
    .level_out  (strap_sync)
  );

  assign fifo_strap  = strap_sync[1];
  assign unipolar    = strap_sync[0];
  // A strap change empties the FIFO so stale samples never mix across modes.
  assign mode_change = fifo_strap != st.fifo_mode;

  // ----------------------------------------------------------------
  // Sample FIFO
  // ----------------------------------------------------------------
  adr_fifo #(
    .WIDTH (ADR_SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock_in   (clock_in),
    .reset_n_in (reset_n_in),
    .flush_in   (mode_change || !st.fifo_mode),
    .wr_port    (push_if),
    .rd_port    (pop_if)
  );

  // Converter samples go to the FIFO in FIFO mode and to the latch otherwise.
  assign push_if.valid    = sample_valid_in && st.fifo_mode;
  assign push_if.data     = sample_data_in;
  // Readout never stalls the converter; only a full FIFO or the flush on a strap change holds it off.
  assign sample_ready_out = st.fifo_mode ? push_if.ready : 1'b1;

  // ----------------------------------------------------------------
  // Host access decode
  // ----------------------------------------------------------------
  always_comb begin
    read_low  = 1'b0;
    read_high = 1'b0;
    write_low = 1'b0;
    if (io_read_in && io_address_in == ADR_OFFS_LOW) begin
      read_low = 1'b1;
    end else if (io_read_in && io_address_in == ADR_OFFS_HIGH) begin
      read_high = 1'b1;
    end
    if (io_write_in && io_address_in == ADR_OFFS_LOW) begin
      write_low = 1'b1;
    end
  end

  // Only the high byte or a whole word consumes a sample; the low byte is a peek.
  assign consume      = st.fifo_mode && ((read_low && io_word_in) || read_high);
  assign pop_if.ready = consume;

  // An empty FIFO answers with the reset value and is not advanced.
  always_comb begin
    if (st.fifo_mode) begin
      head = pop_if.valid ? pop_if.data : ADR_SAMPLE_RST;
    end else begin
      head = st.latest;
    end
  end

  assign coded = adr_encode(head, invert_encoding_in);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st            = st;
    next_st.fifo_mode  = fifo_strap;
    next_st.read_valid = 1'b0;
    next_st.trigger    = 1'b0;

    if (!st.fifo_mode && sample_valid_in) begin
      next_st.latest = sample_data_in;
    end

    if (read_low && io_word_in) begin
      next_st.read_data  = coded;
      next_st.read_valid = 1'b1;
    end else if (read_low) begin
      next_st.read_data  = {ADR_BYTE_PAD, adr_byte(coded, 1'b0)};
      next_st.read_valid = 1'b1;
    end else if (read_high) begin
      next_st.read_data  = {ADR_BYTE_PAD, adr_byte(coded, 1'b1)};
      next_st.read_valid = 1'b1;
    end

    // Any written value triggers; decoding special values is left downstream.
    if (write_low) begin
      next_st.trigger      = 1'b1;
      next_st.trigger_data = io_write_data_in;
    end

    next_st.range_code[ADR_RANGE_UNI] = unipolar;
    next_st.range_code[ADR_RANGE_G1]  = gain_select_high_in;
    next_st.range_code[ADR_RANGE_G0]  = gain_select_low_in;
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st.fifo_mode    <= 1'b0;
      st.latest       <= ADR_SAMPLE_RST;
      st.read_data    <= ADR_SAMPLE_RST;
      st.read_valid   <= 1'b0;
      st.trigger      <= 1'b0;
      st.trigger_data <= ADR_BYTE_RST;
      st.range_code   <= ADR_RANGE_RST;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign io_read_data_out    = st.read_data;
  assign io_read_valid_out   = st.read_valid;
  assign sw_trigger_out      = st.trigger;
  assign sw_trigger_data_out = st.trigger_data;
  assign range_code_out      = st.range_code;
  assign range_bipolar_out   = !st.range_code[ADR_RANGE_UNI];
  assign fifo_mode_out       = st.fifo_mode;
  // Status for the host's empty check; sequencing stays the host's job.
  assign fifo_empty_out      = !pop_if.valid;
  assign fifo_full_out       = st.fifo_mode && !push_if.ready;

endmodule

// [tb/adr_host_model.sv]
// Host bus model making byte and word accesses on the readout port.
`timescale 1ns/1ps
module adr_host_model import adr_pkg::*; (
  input  wire logic                    clock_in,
  input  wire logic [ADR_SAMPLE_W-1:0] read_data_in,
  input  wire logic                    read_valid_in,
  output logic      [ADR_ADDR_W-1:0]   address_out,
  output logic                         read_out,
  output logic                         write_out,
  output logic                         word_out,
  output logic      [ADR_BYTE_W-1:0]   write_data_out
);
  initial begin
    address_out = 4'hf;
    read_out = 1'b0;
    write_out = 1'b0;
    word_out = 1'b0;
    write_data_out = 8'h00;
  end

  // Sequencing of byte pairs and start of acquisition is the caller's job.
  task automatic access(input logic [3:0] a, input logic rd, input logic wd, input logic [7:0] d,
                        output logic [15:0] q, output logic v);
    @(posedge clock_in);
    address_out <= a;
    read_out <= rd;
    write_out <= !rd;
    word_out <= wd;
    write_data_out <= d;
    @(posedge clock_in);
    read_out <= 1'b0;
    write_out <= 1'b0;
    address_out <= ~a;
    write_data_out <= ~d;
    #1;
    q = read_data_in;
    v = read_valid_in;
  endtask
endmodule

// [tb/adr_readout_checker.sv]
// Port-level assertions of the readout port.
`timescale 1ns/1ps
module adr_readout_checker import adr_pkg::*; #(
  parameter int FIFO_DEPTH = ADR_FIFO_DEPTH
) (
  input wire logic                    clock_in,
  input wire logic                    reset_n_in,
  input wire logic [ADR_ADDR_W-1:0]   io_address_in,
  input wire logic                    io_read_in,
  input wire logic                    io_write_in,
  input wire logic                    io_word_in,
  input wire logic [ADR_BYTE_W-1:0]   io_write_data_in,
  input wire logic [ADR_SAMPLE_W-1:0] io_read_data_out,
  input wire logic                    io_read_valid_out,
  input wire logic                    sample_ready_out,
  input wire logic                    sw_trigger_out,
  input wire logic [ADR_BYTE_W-1:0]   sw_trigger_data_out,
  input wire logic                    gain_select_high_in,
  input wire logic                    gain_select_low_in,
  input wire logic                    invert_encoding_in,
  input wire logic [ADR_RANGE_W-1:0]  range_code_out,
  input wire logic                    range_bipolar_out,
  input wire logic                    fifo_mode_out,
  input wire logic                    fifo_empty_out,
  input wire logic                    fifo_full_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  logic map_rd;
  logic trig_wr;
  assign map_rd = io_read_in && (io_address_in <= ADR_OFFS_HIGH);
  assign trig_wr = io_write_in && (io_address_in == ADR_OFFS_LOW);
  a_read_answer: assert property (map_rd |=> io_read_valid_out) else $error("read not answered");
  a_valid_cause: assert property (!map_rd |=> !io_read_valid_out) else $error("stray read valid");
  a_byte_pad: assert property (map_rd && !io_word_in |=> io_read_data_out[15:8] == ADR_BYTE_PAD)
    else $error("byte read upper bits not zero");
  a_trig_pulse: assert property (trig_wr |=> sw_trigger_out && sw_trigger_data_out == $past(io_write_data_in))
    else $error("trigger missing");
  a_trig_cause: assert property (!trig_wr |=> !sw_trigger_out) else $error("stray trigger");
  a_empty_read: assert property (map_rd && io_word_in && io_address_in == ADR_OFFS_LOW && fifo_mode_out
    && fifo_empty_out |=> io_read_data_out == {16{$past(invert_encoding_in)}}) else $error("empty read value");
  a_gain_follow: assert property ($past(reset_n_in) |-> range_code_out[1:0]
    == $past({gain_select_high_in, gain_select_low_in})) else $error("gain bits not followed");
  a_bipolar_tie: assert property (range_bipolar_out == !range_code_out[ADR_RANGE_UNI]) else $error("bipolar");
  a_direct_flags: assert property (!fifo_mode_out |-> fifo_empty_out && !fifo_full_out) else $error("flags");
  a_full_refuse: assert property (fifo_full_out |-> !sample_ready_out) else $error("full but ready");
endmodule

bind adr_readout_port adr_readout_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_chk (.clock_in, .reset_n_in, .io_address_in,
  .io_read_in, .io_write_in, .io_word_in, .io_write_data_in, .io_read_data_out, .io_read_valid_out, .sample_ready_out,
  .sw_trigger_out, .sw_trigger_data_out, .gain_select_high_in, .gain_select_low_in, .invert_encoding_in,
  .range_code_out, .range_bipolar_out, .fifo_mode_out, .fifo_empty_out, .fifo_full_out);

// [tb/adr_readout_port_tb.sv]
// Self-checking bench of the readout port with a host model and a sample source.
`timescale 1ns/1ps
module adr_readout_port_tb import adr_pkg::*; ;
  // ----------------------------------------------------------------
  // Signals and models
  // ----------------------------------------------------------------
  logic clock_in = 1'b0, reset_n_in = 1'b0, io_read_in, io_write_in, io_word_in, io_read_valid_out;
  logic sample_valid_in = 1'b0, sample_ready_out, sw_trigger_out, fifo_mode_strap_in = 1'b0;
  logic unipolar_strap_in = 1'b0, gain_select_high_in = 1'b0, gain_select_low_in = 1'b0;
  logic invert_encoding_in = 1'b0, range_bipolar_out, fifo_mode_out, fifo_empty_out, fifo_full_out, v;
  logic [3:0] io_address_in;
  logic [7:0] io_write_data_in, sw_trigger_data_out, d;
  logic [2:0] range_code_out;
  logic [15:0] sample_data_in = 16'h0000, io_read_data_out, q, e, s;
  logic [15:0] pat[4];
  logic [15:0] fq[$];
  int miscompares = 0, num_checks = 0, cycles = 0, n;

  adr_readout_port #(.FIFO_DEPTH(ADR_FIFO_DEPTH)) u_dut (.clock_in, .reset_n_in, .io_address_in, .io_read_in,
    .io_write_in, .io_word_in, .io_write_data_in, .io_read_data_out, .io_read_valid_out, .sample_valid_in,
    .sample_data_in, .sample_ready_out, .sw_trigger_out, .sw_trigger_data_out, .fifo_mode_strap_in,
    .unipolar_strap_in, .gain_select_high_in, .gain_select_low_in, .invert_encoding_in, .range_code_out,
    .range_bipolar_out, .fifo_mode_out, .fifo_empty_out, .fifo_full_out);
  adr_host_model u_host (.clock_in, .read_data_in(io_read_data_out), .read_valid_in(io_read_valid_out),
    .address_out(io_address_in), .read_out(io_read_in), .write_out(io_write_in), .word_out(io_word_in),
    .write_data_out(io_write_data_in));

  always #5 clock_in = ~clock_in;
  // The ceiling is far above the few hundred cycles the tests need.
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end

  function automatic logic [15:0] coded(input logic [15:0] raw, input logic inv);
    return inv ? ~raw : raw;
  endfunction

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic push(input logic [15:0] x);
    @(posedge clock_in);
    sample_valid_in <= 1'b1;
    sample_data_in <= x;
    @(negedge clock_in);
    while (!sample_ready_out) @(negedge clock_in);
    @(posedge clock_in);
    sample_valid_in <= 1'b0;
    sample_data_in <= ~x;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(33499));
    repeat (6) @(posedge clock_in);
    reset_n_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    pat = '{16'h0000, 16'hffff, 16'($urandom), 16'($urandom)};
    for (int k = 0; k < 8; k++) begin
      push(pat[k/2]);
      invert_encoding_in <= k[0];
      e = coded(pat[k/2], k[0]);
      u_host.access(ADR_OFFS_HIGH, 1'b1, 1'b0, 8'h00, q, v);
      chk("high byte", {8'h00, e[15:8]}, q);
      u_host.access(ADR_OFFS_LOW, 1'b1, 1'b0, 8'h00, q, v);
      chk("low byte", {8'h00, e[7:0]}, q);
      u_host.access(ADR_OFFS_LOW, 1'b1, 1'b1, 8'h00, q, v);
      chk("word", e, q);
      chk("read valid", 16'h0001, {15'h0000, v});
    end
    u_host.access(4'h5, 1'b1, 1'b0, 8'h00, q, v);
    chk("unmapped valid", 16'h0000, {15'h0000, v});
    $display("test direct readout done");
    for (int k = 0; k < 4; k++) begin
      d = 8'($urandom);
      u_host.access(k[0] ? ADR_OFFS_HIGH : ADR_OFFS_LOW, 1'b0, 1'b0, d, q, v);
      chk("trigger", {15'h0000, !k[0]}, {15'h0000, sw_trigger_out});
      if (!k[0]) chk("trigger data", {8'h00, d}, {8'h00, sw_trigger_data_out});
    end
    for (int k = 0; k < 8; k++) begin
      @(posedge clock_in);
      {unipolar_strap_in, gain_select_high_in, gain_select_low_in} <= 3'(k);
      repeat (4) @(posedge clock_in);
      #1;
      chk("range", 16'(k), {13'h0000, range_code_out});
      chk("bipolar", {15'h0000, !k[2]}, {15'h0000, range_bipolar_out});
    end
    $display("test trigger and range done");
    @(posedge clock_in);
    fifo_mode_strap_in <= 1'b1;
    repeat (6) @(posedge clock_in);
    chk("fifo mode", 16'h0001, {15'h0000, fifo_mode_out});
    for (int i = 0; i < ADR_FIFO_DEPTH; i++) begin
      s = 16'($urandom);
      fq.push_back(s);
      push(s);
    end
    #1;
    chk("full refuses", 16'h0002, {14'h0000, fifo_full_out, sample_ready_out});
    n = 0;
    while (fq.size() != 0) begin
      if (n % 4 == 2 && n < 20) begin
        s = 16'($urandom);
        fq.push_back(s);
        push(s);
      end
      e = coded(fq.pop_front(), invert_encoding_in);
      if (n % 2 == 1) begin
        u_host.access(ADR_OFFS_LOW, 1'b1, 1'b0, 8'h00, q, v);
        chk("fifo low", {8'h00, e[7:0]}, q);
        u_host.access(ADR_OFFS_HIGH, 1'b1, 1'b0, 8'h00, q, v);
        chk("fifo high", {8'h00, e[15:8]}, q);
      end else begin
        u_host.access(ADR_OFFS_LOW, 1'b1, 1'b1, 8'h00, q, v);
        chk("fifo word", e, q);
      end
      n++;
    end
    chk("empty flag", 16'h0001, {15'h0000, fifo_empty_out});
    u_host.access(ADR_OFFS_LOW, 1'b1, 1'b1, 8'h00, q, v);
    chk("empty read", coded(16'h0000, invert_encoding_in), q);
    push(16'h5a3c);
    u_host.access(ADR_OFFS_LOW, 1'b1, 1'b1, 8'h00, q, v);
    chk("after empty", coded(16'h5a3c, invert_encoding_in), q);
    $display("test fifo readout done");
    conclude();
  end
endmodule
